// *** inc/lbc_defs.vh ***
// Functional notes
// R1: lockout disables all regulators, then restart
// R2: each enable pin gates only its rail
// R3: either enable pin high enables boost
// R4: boost starts only above lockout with enable
// R5: positive rail needs pin and soft-start done
// R6: negative rail needs pin and soft-start done
// R7: one pin low stops only its rail
// R8: both pins low stop rails and boost
// R9: slave answers to seven-bit address 3eh
// R10: direction bit zero writes, one reads
// R11: rail codes at 00h, 01h; discharge 03h
// R12: discharge bit1 positive, bit0 negative
// R13: rail codes step 0.1 V, four bits
// R14: register address byte sets first register
// R15: address increments after each data byte
// R16: slave usable only after enable delay
// R17: host reads via address write, restart
// R18: master ack continues read, nack ends
// R19: discharge asserted when selected and rail off
// R20: unused bits read zero, unmapped ignored
`ifndef LBC_DEFS_VH
`define LBC_DEFS_VH

// i2c slave address and direction
`define LBC_SLAVE_ADDR   7'h3e
`define LBC_DIR_WRITE    1'b0
`define LBC_DIR_READ     1'b1

// register offsets
`define LBC_OFS_POS      8'h00
`define LBC_OFS_NEG      8'h01
`define LBC_OFS_DIS      8'h03

// field layout and reset values
`define LBC_CODE_W       4
`define LBC_DIS_POS_BIT  1
`define LBC_DIS_NEG_BIT  0
`define LBC_CODE_RST     4'h0
`define LBC_DIS_RST      2'h0

// bit counting within a byte
`define LBC_BITS_BYTE    4'h8
`define LBC_BIT_ONE      4'h1
`define LBC_BIT_ZERO     4'h0

// enable-to-interface delay: 0.5 ms, clock 20 MHz
`define LBC_T_EN_I2C_US  500
`define LBC_CLK_MHZ      20
`define LBC_EN_CNT_W     14

`endif

// *** verilog/lbc_sync.v ***
`timescale 1ns/100ps
// two-flop synchroniser, one stage pair per bit
module lbc_sync #(
  parameter       W   = 1,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  // clock and reset
  input  wire         sys_clk_in,
  input  wire         rst_b_in,
  // asynchronous inputs and synchronised outputs
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta;
      reg stable;
      // first flop feeds only the second
      always @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
          meta   <= RST[i];
          stable <= RST[i];
        end else begin
          meta   <= async_in[i];
          stable <= meta;
        end
      end
      assign sync_out[i] = stable;
    end
  endgenerate

endmodule // lbc_sync

// *** verilog/lbc_regs.v ***
`timescale 1ns/100ps
`include "lbc_defs.vh"

module lbc_regs #(
  parameter EN_I2C_CYCLES = `LBC_T_EN_I2C_US * `LBC_CLK_MHZ
) (
  // clock and reset
  input  wire                   sys_clk_in,
  input  wire                   rst_b_in,
  // i2c pins, sda open drain
  input  wire                   scl_in,
  input  wire                   sda_in,
  output wire                   sda_out,
  output reg                    sda_oe_b_out,
  // enable pins and analog status
  input  wire                   pos_rail_enable_pin_in,
  input  wire                   neg_rail_enable_pin_in,
  input  wire                   input_lockout_in,
  input  wire                   boost_ss_done_in,
  // regulator controls
  output reg                    boost_stage_en_out,
  output reg                    positive_rail_en_out,
  output reg                    negative_rail_en_out,
  output reg                    pos_discharge_out,
  output reg                    neg_discharge_out,
  // rail voltage codes
  output reg [`LBC_CODE_W-1:0]  positive_rail_code_out,
  output reg [`LBC_CODE_W-1:0]  negative_rail_code_out,
  // interface ready indication
  output reg                    i2c_ready_out
);

  // slave states
  localparam [3:0] ST_IDLE   = 4'h0;
  localparam [3:0] ST_DEV    = 4'h1;
  localparam [3:0] ST_DEVACK = 4'h2;
  localparam [3:0] ST_REGA   = 4'h3;
  localparam [3:0] ST_REGACK = 4'h4;
  localparam [3:0] ST_WDAT   = 4'h5;
  localparam [3:0] ST_WACK   = 4'h6;
  localparam [3:0] ST_RDAT   = 4'h7;
  localparam [3:0] ST_RACK   = 4'h8;

  // counter width is fixed; the last count is cut to it on purpose
  localparam integer             EN_LAST_I = EN_I2C_CYCLES - 1;
  localparam [`LBC_EN_CNT_W-1:0] EN_LAST   = EN_LAST_I[`LBC_EN_CNT_W-1:0];

  // synchronised pins
  wire [5:0] pins_s;
  wire       scl_s;
  wire       sda_s;
  wire       enp_s;
  wire       enn_s;
  wire       lock_s;
  wire       ssd_s;

  // every pin crosses into the clock domain through two flops
  // scl and sda idle high, so they reset high
  lbc_sync #(
    .W   (6),
    .RST (6'h03)
  ) u_sync (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .async_in   ({boost_ss_done_in, input_lockout_in, neg_rail_enable_pin_in,
                  pos_rail_enable_pin_in, sda_in, scl_in}),
    .sync_out   (pins_s)
  );

  assign scl_s  = pins_s[0];
  assign sda_s  = pins_s[1];
  assign enp_s  = pins_s[2];
  assign enn_s  = pins_s[3];
  assign lock_s = pins_s[4];
  assign ssd_s  = pins_s[5];

  // the pin is never driven high; the pull-up does that
  // open drain: only the enable ever changes
  assign sda_out = 1'b0;

  // lockout acts as a reset of the whole control state
  wire clr = !rst_b_in || lock_s; // R1

  // registers
  reg [`LBC_CODE_W-1:0] pos_code;
  reg [`LBC_CODE_W-1:0] neg_code;
  reg [1:0]             dis_sel;

  // power sequencing
  wire any_en     = enp_s || enn_s; // R3
  wire next_boost = any_en && !lock_s; // R4 R8
  wire next_pos   = enp_s && next_boost && ssd_s; // R2 R5 R7
  wire next_neg   = enn_s && next_boost && ssd_s; // R2 R6 R7

  // outputs registered; soft-start done is low again after lockout
  always @(posedge sys_clk_in) begin
    if (clr) begin
      boost_stage_en_out   <= 1'b0; // R1
      positive_rail_en_out <= 1'b0;
      negative_rail_en_out <= 1'b0;
      pos_discharge_out    <= 1'b0;
      neg_discharge_out    <= 1'b0;
    end else begin
      boost_stage_en_out   <= next_boost;
      positive_rail_en_out <= next_pos;
      negative_rail_en_out <= next_neg;
      pos_discharge_out    <= dis_sel[`LBC_DIS_POS_BIT] && !next_pos; // R19
      neg_discharge_out    <= dis_sel[`LBC_DIS_NEG_BIT] && !next_neg; // R19
    end
  end

  // interface wake-up timer after an enable rises
  reg [`LBC_EN_CNT_W-1:0] en_cnt;
  always @(posedge sys_clk_in) begin
    if (clr || !any_en) begin
      en_cnt        <= {`LBC_EN_CNT_W{1'b0}};
      i2c_ready_out <= 1'b0;
    end else if (en_cnt == EN_LAST) begin
      i2c_ready_out <= 1'b1; // R16
    end else begin
      en_cnt <= en_cnt + 1'b1;
    end
  end

  // bus edge and condition detection
  reg  scl_d;
  reg  sda_d;
  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire start_c  = scl_s && scl_d && sda_d && !sda_s;
  wire stop_c   = scl_s && scl_d && !sda_d && sda_s;

  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // unmapped offsets read zero and change nothing
  // read data mux, unused bits zero
  reg [7:0] rd_byte;
  reg [7:0] ptr;
  always @* begin
    rd_byte = 8'h00; // R20
    if (ptr == `LBC_OFS_POS) begin
      rd_byte[`LBC_CODE_W-1:0] = pos_code;
    end else if (ptr == `LBC_OFS_NEG) begin
      rd_byte[`LBC_CODE_W-1:0] = neg_code;
    end else if (ptr == `LBC_OFS_DIS) begin
      rd_byte[1:0] = dis_sel; // R12
    end
  end

  // slave state
  reg [3:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shreg;
  reg [7:0] tx;
  reg       rw;
  reg       more;
  reg       wr_stb;

  // start and stop win over any bit in flight, so a cut frame ends cleanly
  // byte engine; sampled on scl rise, driven after scl fall
  always @(posedge sys_clk_in) begin
    if (clr) begin
      state        <= ST_IDLE;
      bit_cnt      <= `LBC_BIT_ZERO;
      shreg        <= 8'h00;
      tx           <= 8'h00;
      rw           <= `LBC_DIR_WRITE;
      more         <= 1'b0;
      ptr          <= 8'h00;
      wr_stb       <= 1'b0;
      sda_oe_b_out <= 1'b1;
    end else begin
      wr_stb <= 1'b0;
      if (start_c) begin
        state        <= ST_DEV; // R17
        bit_cnt      <= `LBC_BIT_ZERO;
        sda_oe_b_out <= 1'b1;
      end else if (stop_c) begin
        state        <= ST_IDLE;
        sda_oe_b_out <= 1'b1;
      end else begin
        case (state)
          ST_DEV, ST_REGA, ST_WDAT: begin
            if (scl_rise) begin
              shreg   <= {shreg[6:0], sda_s};
              bit_cnt <= bit_cnt + `LBC_BIT_ONE;
            end else if (scl_fall && bit_cnt == `LBC_BITS_BYTE) begin
              bit_cnt <= `LBC_BIT_ZERO;
              if (state == ST_DEV) begin
                if (shreg[7:1] == `LBC_SLAVE_ADDR && i2c_ready_out) begin // R9 R16
                  rw           <= shreg[0]; // R10
                  sda_oe_b_out <= 1'b0;
                  state        <= ST_DEVACK;
                end else begin
                  state <= ST_IDLE;
                end
              end else if (state == ST_REGA) begin
                ptr          <= shreg; // R14
                sda_oe_b_out <= 1'b0;
                state        <= ST_REGACK;
              end else begin
                wr_stb       <= 1'b1;
                sda_oe_b_out <= 1'b0;
                state        <= ST_WACK;
              end
            end
          end
          ST_DEVACK: begin
            if (scl_fall) begin
              if (rw == `LBC_DIR_READ) begin
                tx           <= {rd_byte[6:0], 1'b0};
                sda_oe_b_out <= rd_byte[7];
                bit_cnt      <= `LBC_BIT_ONE;
                state        <= ST_RDAT;
              end else begin
                sda_oe_b_out <= 1'b1;
                state        <= ST_REGA;
              end
            end
          end
          ST_REGACK, ST_WACK: begin
            if (scl_fall) begin
              sda_oe_b_out <= 1'b1;
              state        <= ST_WDAT;
            end
          end
          ST_RDAT: begin
            if (scl_fall) begin
              if (bit_cnt == `LBC_BITS_BYTE) begin
                sda_oe_b_out <= 1'b1;
                ptr          <= ptr + 8'h01; // R15
                state        <= ST_RACK;
              end else begin
                sda_oe_b_out <= tx[7];
                tx           <= {tx[6:0], 1'b0};
                bit_cnt      <= bit_cnt + `LBC_BIT_ONE;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              more <= !sda_s; // R18
            end else if (scl_fall) begin
              if (more) begin
                tx           <= {rd_byte[6:0], 1'b0};
                sda_oe_b_out <= rd_byte[7];
                bit_cnt      <= `LBC_BIT_ONE;
                state        <= ST_RDAT; // R18
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
        // pointer advances once the written byte is stored
        if (wr_stb) begin
          ptr <= ptr + 8'h01; // R15
        end
      end
    end
  end

  // register writes; unmapped offsets take no effect
  always @(posedge sys_clk_in) begin
    if (clr) begin
      pos_code <= `LBC_CODE_RST;
      neg_code <= `LBC_CODE_RST;
      dis_sel  <= `LBC_DIS_RST;
    end else if (wr_stb) begin
      if (ptr == `LBC_OFS_POS) begin
        pos_code <= shreg[`LBC_CODE_W-1:0]; // R11 R13
      end else if (ptr == `LBC_OFS_NEG) begin
        neg_code <= shreg[`LBC_CODE_W-1:0]; // R11 R13
      end else if (ptr == `LBC_OFS_DIS) begin
        dis_sel <= shreg[1:0]; // R12 R20
      end
    end
  end

  // registered copy keeps the reference inputs free of decode glitches
  // codes to the analog references
  always @(posedge sys_clk_in) begin
    if (clr) begin
      positive_rail_code_out <= `LBC_CODE_RST;
      negative_rail_code_out <= `LBC_CODE_RST;
    end else begin
      positive_rail_code_out <= pos_code;
      negative_rail_code_out <= neg_code;
    end
  end

endmodule // lbc_regs

// *** bench/lbc_regs_chk.sv ***
`timescale 1ns/100ps
// power-path checks; pins need three edges to reach outputs, windows leave margin
module lbc_regs_chk (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // pins and status
  input wire logic pos_rail_enable_pin_in,
  input wire logic neg_rail_enable_pin_in,
  input wire logic input_lockout_in,
  input wire logic boost_ss_done_in,
  // regulator controls and interface ready
  input wire logic boost_stage_en_out,
  input wire logic positive_rail_en_out,
  input wire logic negative_rail_en_out,
  input wire logic pos_discharge_out,
  input wire logic neg_discharge_out,
  input wire logic i2c_ready_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // either pin asks for the boost stage
  wire any_en = pos_rail_enable_pin_in | neg_rail_enable_pin_in;

  property p_boost_on; (any_en && !input_lockout_in)[*5] |-> boost_stage_en_out; endproperty
  a_boost_on: assert property (p_boost_on) else $error("boost stage not on");
  property p_boost_off; (!any_en)[*5] |-> !boost_stage_en_out; endproperty
  a_boost_off: assert property (p_boost_off) else $error("boost stage not off");
  property p_lock_off;
    input_lockout_in[*5] |-> !(boost_stage_en_out | positive_rail_en_out | negative_rail_en_out);
  endproperty
  a_lock_off: assert property (p_lock_off) else $error("regulator on under lockout");
  property p_pos_on;
    (pos_rail_enable_pin_in && boost_ss_done_in && !input_lockout_in)[*6] |-> positive_rail_en_out;
  endproperty
  a_pos_on: assert property (p_pos_on) else $error("positive rail not on");
  property p_neg_on;
    (neg_rail_enable_pin_in && boost_ss_done_in && !input_lockout_in)[*6] |-> negative_rail_en_out;
  endproperty
  a_neg_on: assert property (p_neg_on) else $error("negative rail not on");
  property p_pos_off; (!pos_rail_enable_pin_in || !boost_ss_done_in)[*5] |-> !positive_rail_en_out; endproperty
  a_pos_off: assert property (p_pos_off) else $error("positive rail not off");
  property p_neg_off; (!neg_rail_enable_pin_in)[*5] |-> !negative_rail_en_out; endproperty
  a_neg_off: assert property (p_neg_off) else $error("negative rail not off");
  property p_ready_off; (!any_en)[*5] |-> !i2c_ready_out; endproperty
  a_ready_off: assert property (p_ready_off) else $error("interface ready while disabled");
endmodule // lbc_regs_chk

// *** bench/lbc_host.sv ***
`timescale 1ns/100ps
// behavioural i2c master; scl stands still between frames
module lbc_host (
  // bus lines, high means released to the pull-up
  output logic scl_out,
  output logic sda_rel_out,
  input  wire  sda_in
);
  initial begin
    scl_out = 1'b1;
    sda_rel_out = 1'b1;
  end
  // one bit: data set in low phase, sampled mid high phase
  task bit_io(input logic b, output logic r);
    sda_rel_out = b;
    #100 scl_out = 1'b1;
    #100 r = sda_in;
    #100 scl_out = 1'b0;
    #100;
  endtask
  // also serves as repeated start before a read
  task i2c_start;
    sda_rel_out = 1'b1;
    #100 scl_out = 1'b1;
    #100 sda_rel_out = 1'b0;
    #100 scl_out = 1'b0;
    #100;
  endtask
  task i2c_stop;
    sda_rel_out = 1'b0;
    #100 scl_out = 1'b1;
    #100 sda_rel_out = 1'b1;
    #100;
  endtask
  // msb first, then ack slot released
  task wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // master ack asks for the next register, nack ends the read
  task rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!mack, r);
  endtask
endmodule // lbc_host

// *** bench/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  logic       clk, rst_b, pos_rail_enable_pin, neg_rail_enable_pin, lock, ss, a;
  logic [7:0] r;
  wire        scl, sda_h, sda_d, sda_oe_b, boost, pos, neg, pdis, ndis, rdy;
  wire  [3:0] pcode, ncode;
  wire        sda = sda_h & (sda_oe_b | sda_d);
  wire  [7:0] outs = {3'h0, boost, pos, neg, pdis, ndis};
  int         n_mismatch = 0;
  int         checked = 0;
  // short enable delay keeps the run brief
  lbc_regs #(.EN_I2C_CYCLES(20)) lbc_regs_i (.sys_clk_in(clk), .rst_b_in(rst_b), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_d), .sda_oe_b_out(sda_oe_b), .pos_rail_enable_pin_in(pos_rail_enable_pin),
    .neg_rail_enable_pin_in(neg_rail_enable_pin), .input_lockout_in(lock), .boost_ss_done_in(ss),
    .boost_stage_en_out(boost), .positive_rail_en_out(pos), .negative_rail_en_out(neg),
    .pos_discharge_out(pdis), .neg_discharge_out(ndis), .positive_rail_code_out(pcode),
    .negative_rail_code_out(ncode), .i2c_ready_out(rdy));
  lbc_host lbc_host_i (.scl_out(scl), .sda_rel_out(sda_h), .sda_in(sda));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // pins change just after an edge, outputs read once settled
  task drv(input logic p, input logic n, input logic l, input logic s);
    {pos_rail_enable_pin, neg_rail_enable_pin, lock, ss} = {p, n, l, s};
    wt(8);
  endtask
  task wb(input logic [7:0] d, input logic exp);
    lbc_host_i.wbyte(d, a);
    chk({7'h0, a}, {7'h0, exp});
  endtask
  task rb(input logic mack, input logic [7:0] exp);
    lbc_host_i.rbyte(mack, r);
    chk(r, exp);
  endtask
  task t_power;
    drv(1, 0, 0, 0); chk(outs, 8'h10);
    drv(1, 0, 0, 1); chk(outs, 8'h18);
    drv(1, 1, 0, 1); chk(outs, 8'h1c);
    drv(0, 1, 0, 1); chk(outs, 8'h14);
    drv(0, 1, 1, 1); chk(outs, 8'h00);
    drv(0, 1, 0, 1); chk(outs, 8'h14);
    drv(0, 0, 0, 1); chk(outs, 8'h00);
  endtask
  task t_ready;
    drv(1, 0, 0, 1); chk({7'h0, rdy}, 8'h00);
    wt(30); chk({7'h0, rdy}, 8'h01);
  endtask
  // burst write over the gap at 02h, then burst read back
  task t_regs;
    lbc_host_i.i2c_start;
    wb(8'h7c, 1);
    wb(8'h00, 1);
    wb(8'ha5, 1); wb(8'h3c, 1); wb(8'hff, 1); wb(8'hff, 1);
    lbc_host_i.i2c_stop;
    wt(8); chk({pcode, ncode}, 8'h5c);
    chk(outs, 8'h19);
    lbc_host_i.i2c_start;
    wb(8'h7c, 1); wb(8'h00, 1);
    lbc_host_i.i2c_start;
    wb(8'h7d, 1);
    rb(1, 8'h05); rb(1, 8'h0c); rb(1, 8'h00); rb(0, 8'h03);
    lbc_host_i.i2c_stop;
  endtask
  // foreign address gets no ack and writes nothing
  task t_addr;
    lbc_host_i.i2c_start;
    wb(8'h7e, 0); wb(8'h00, 0); wb(8'h11, 0);
    lbc_host_i.i2c_stop;
    wt(8); chk({pcode, ncode}, 8'h5c);
  endtask
  // discharge follows its select bits, lockout clears them, no ack while disabled
  task t_dis;
    drv(0, 1, 0, 1); chk(outs, 8'h16);
    drv(0, 0, 0, 1); chk(outs, 8'h03);
    drv(0, 0, 1, 1); chk({pcode, ncode}, 8'h00);
    drv(0, 0, 0, 1); chk(outs, 8'h00);
    lbc_host_i.i2c_start;
    wb(8'h7c, 0);
    lbc_host_i.i2c_stop;
  endtask
  task print_verdict;
    if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    print_verdict;
  end
  initial begin
    rst_b = 1'b0;
    {pos_rail_enable_pin, neg_rail_enable_pin, lock, ss} = 4'h0;
    repeat (5) @(posedge clk);
    #1 rst_b = 1'b1;
    t_power;
    t_ready;
    t_regs;
    t_addr;
    t_dis;
    print_verdict;
  end
endmodule // tb_top

bind lbc_regs lbc_regs_chk lbc_regs_chk_i (.sys_clk_in, .rst_b_in, .pos_rail_enable_pin_in,
  .neg_rail_enable_pin_in, .input_lockout_in, .boost_ss_done_in, .boost_stage_en_out,
  .positive_rail_en_out, .negative_rail_en_out, .pos_discharge_out, .neg_discharge_out, .i2c_ready_out);
